// ---- mhp_pkg.sv ----
// package: constants and types for the mac header field parser
package mhp_pkg;
  // addressing mode encodings
  localparam logic [1:0] MHP_AM_NONE  = 2'h0;
  localparam logic [1:0] MHP_AM_RSVD  = 2'h1;
  localparam logic [1:0] MHP_AM_SHORT = 2'h2;
  localparam logic [1:0] MHP_AM_EXT   = 2'h3;
  // frame control field bit positions
  localparam int MHP_FC_SEC    = 3;
  localparam int MHP_FC_PANC   = 6;
  localparam int MHP_FC_DAM_LO = 10;
  localparam int MHP_FC_VER_LO = 12;
  localparam int MHP_FC_SAM_LO = 14;
  // field lengths in octets
  localparam logic [3:0] MHP_LEN_PAN   = 4'h2;
  localparam logic [3:0] MHP_LEN_SHORT = 4'h2;
  localparam logic [3:0] MHP_LEN_EXT   = 4'h8;
  localparam logic [3:0] MHP_LEN_FCS   = 4'h2;
  // security header length, a plain default
  localparam logic [3:0] MHP_LEN_AUX   = 4'h5;
  // reset values and fifo depth
  localparam logic [15:0] MHP_FC_RST   = 16'h0000;
  localparam logic [7:0]  MHP_SEQ_RST  = 8'h00;
  localparam logic [3:0]  MHP_VPOL_RST = 4'h3;
  localparam int          MHP_FIFO_DEPTH = 8;

  // parser states, one-hot
  typedef enum logic [7:0] {
    MHP_IDLE = 8'h01,
    MHP_FC   = 8'h02,
    MHP_SEQ  = 8'h04,
    MHP_DST  = 8'h08,
    MHP_SRC  = 8'h10,
    MHP_AUX  = 8'h20,
    MHP_PAY  = 8'h40,
    MHP_DONE = 8'h80
  } mhp_state_t;

  // octets taken by one addressing field
  function automatic logic [3:0] mhp_addr_len(input logic [1:0] am,
                                              input logic       pan);
    logic [3:0] a;
    a = (am == MHP_AM_EXT)   ? MHP_LEN_EXT :
        (am == MHP_AM_SHORT) ? MHP_LEN_SHORT : 4'h0;
    mhp_addr_len = (a != 4'h0 && pan) ? 4'(a + MHP_LEN_PAN) : a;
  endfunction : mhp_addr_len
endpackage : mhp_pkg

// ---- mhp_fifo.sv ----
// file: small valid/ready fifo for received octets
`timescale 1ns/10ps
module mhp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  // write side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // read side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  wire              wr_en;
  wire              rd_en;

  // honest full and empty
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign wr_en     = in_valid & in_ready;
  assign rd_en     = out_valid & out_ready;
  assign out_data  = mem_r[rp_r];

  // storage
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
      mem_r[wp_r] <= in_data;
  end

  // pointers and fill count
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (wr_en)
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : AW'(wp_r + 1'b1);
      if (rd_en)
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : AW'(rp_r + 1'b1);
      cnt_r <= (AW+1)'(cnt_r + {{AW{1'b0}}, wr_en}
                             - {{AW{1'b0}}, rd_en});
    end
  end
endmodule : mhp_fifo

// ---- mhp_parser.sv ----
// file: mac header field parser for received frames
// Overview of operation
// R01: mode 2 short address, 3 extended
// R02: mode 0 absent, mode 1 reserved
// R03: destination PAN id precedes its address
// R04: frame version from control bits 13:12
// R05: ack decision from version and policy
// R06: source mode from control bits 15:14
// R07: octet after control field is sequence
// R08: ack copies the received sequence number
// R09: destination field before source field
// R10: compression drops source PAN when both present
// R11: aux security header only when secured
// R12: last two octets are the checksum
// R13: forward filter bits of the control field
// R14: secure flag with version names format
// R15: transmitter omits both addresses only in acks
// R16: destination mode from control bits 11:10
// R17: control bit 3 is security flag
// R18: control bit 6 is PAN compression
// R19: field offsets tracked as octets arrive
`timescale 1ns/10ps
module mhp_parser #(
  parameter int DEPTH = mhp_pkg::MHP_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // received octet stream, last marks the final octet
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  // configuration
  input  wire logic        auto_ack_receive_state,
  input  wire logic [3:0]  ack_version_policy,
  input  wire logic [7:0]  frame_len,
  // decoded header
  output logic             hdr_valid,
  output logic [15:0]      frame_ctrl,
  output logic [7:0]       seq_num,
  output logic [1:0]       dst_mode,
  output logic [1:0]       src_mode,
  output logic [1:0]       frame_ver,
  output logic             dst_present,
  output logic             src_present,
  output logic             src_pan_present,
  output logic             addr_mode_rsvd,
  output logic             ver_rsvd,
  output logic             sec_2006,
  output logic             sec_2003,
  output logic [10:0]      filter_bits,
  output logic [7:0]       dst_off,
  output logic [7:0]       src_off,
  output logic [7:0]       aux_off,
  output logic [7:0]       pay_off,
  output logic [7:0]       fcs_off,
  // acknowledgement request
  output logic             ack_allow,
  output logic [7:0]       ack_seq
);
  import mhp_pkg::*;

  mhp_state_t   st_r, st_nxt;
  logic [15:0]  fc_r;
  logic [7:0]   seq_r;
  logic [7:0]   pos_r;
  logic [3:0]   left_r;
  logic [7:0]   doff_r, soff_r, aoff_r, poff_r, foff_r;
  logic         hv_r;
  logic         ack_r;
  wire          f_valid;
  wire          f_ready;
  wire  [8:0]   f_data;
  wire          take;
  wire  [7:0]   byt;
  wire  [1:0]   dam, sam, ver;
  wire          sec, panc;
  wire  [3:0]   dlen, slen, alen;
  wire          fld_end;

  // octet buffer ahead of the parser; it drains every cycle it holds data, except while the parser is in MHP_DONE
  mhp_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .in_data   ({rx_last, rx_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );
  assign f_ready = (st_r != MHP_DONE);
  assign take    = f_valid & f_ready;
  assign byt     = f_data[7:0];

  // control field decode
  assign dam  = fc_r[MHP_FC_DAM_LO +: 2];  // see R16
  assign sam  = fc_r[MHP_FC_SAM_LO +: 2];  // see R06
  assign ver  = fc_r[MHP_FC_VER_LO +: 2];  // see R04
  assign sec  = fc_r[MHP_FC_SEC];          // see R17
  assign panc = fc_r[MHP_FC_PANC];         // see R18
  // field lengths: PAN id first, compressed when both present
  assign dlen = mhp_addr_len(dam, 1'b1);   // see R01 R02 R03
  assign slen = mhp_addr_len(sam,          // see R10
                  !(panc && dlen != 4'h0 && sam[1]));
  assign alen = sec ? MHP_LEN_AUX : 4'h0;  // see R11
  assign fld_end = (left_r == 4'h1);

  // next state: control, sequence, dest, source, aux, payload
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      MHP_IDLE: if (take) st_nxt = MHP_FC;
      MHP_FC:   if (take) st_nxt = MHP_SEQ;
      MHP_SEQ:  if (take) st_nxt = (dlen != 4'h0) ? MHP_DST :   // see R09
                                   (slen != 4'h0) ? MHP_SRC :
                                   (alen != 4'h0) ? MHP_AUX : MHP_PAY;
      MHP_DST:  if (take && fld_end)
                  st_nxt = (slen != 4'h0) ? MHP_SRC :
                           (alen != 4'h0) ? MHP_AUX : MHP_PAY;
      MHP_SRC:  if (take && fld_end)
                  st_nxt = (alen != 4'h0) ? MHP_AUX : MHP_PAY;
      MHP_AUX:  if (take && fld_end) st_nxt = MHP_PAY;
      MHP_PAY:  ;
      MHP_DONE: st_nxt = MHP_IDLE;
      default:  st_nxt = MHP_IDLE;
    endcase
    if (take && f_data[8])
      st_nxt = MHP_DONE;
  end

  // state, octet position and field countdown
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r   <= MHP_IDLE;
      pos_r  <= 8'h00;
      left_r <= 4'h0;
    end
    else
    begin
      st_r  <= st_nxt;
      if (st_nxt == MHP_IDLE)
        pos_r <= 8'h00;
      else if (take)
        pos_r <= 8'(pos_r + 8'h01);
      if (st_nxt == MHP_IDLE)
        left_r <= 4'h0;                    // no stale countdown
      else if (take)
        left_r <= (st_nxt == MHP_DST && st_r != MHP_DST) ? dlen :
                  (st_nxt == MHP_SRC && st_r != MHP_SRC) ? slen :
                  (st_nxt == MHP_AUX && st_r != MHP_AUX) ? alen :
                  (left_r != 4'h0) ? 4'(left_r - 4'h1) : 4'h0;
    end
  end

  // capture control field and sequence number
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fc_r  <= MHP_FC_RST;
      seq_r <= MHP_SEQ_RST;
    end
    else
    begin
      if (take && st_r == MHP_IDLE)
        fc_r[7:0] <= byt;
      if (take && st_r == MHP_FC)
        fc_r[15:8] <= byt;
      if (take && st_r == MHP_SEQ)
        seq_r <= byt;                       // see R07
    end
  end

  // field offsets computed as octets arrive
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      doff_r <= 8'h00;
      soff_r <= 8'h00;
      aoff_r <= 8'h00;
      poff_r <= 8'h00;
      foff_r <= 8'h00;
    end
    else if (take && st_r == MHP_SEQ)
    begin
      doff_r <= 8'(pos_r + 8'h01);         // see R19
      soff_r <= 8'(pos_r + 8'h01 + dlen);
      aoff_r <= 8'(pos_r + 8'h01 + dlen + slen);
      poff_r <= 8'(pos_r + 8'h01 + dlen + slen + alen);
      foff_r <= 8'(frame_len - {4'h0, MHP_LEN_FCS});  // see R12
    end
  end

  // header valid once the payload starts, held to frame end
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hv_r  <= 1'b0;
      ack_r <= 1'b0;
    end
    else
    begin
      if (st_r == MHP_DONE || (take && st_r == MHP_IDLE))
        hv_r <= 1'b0;
      else if (st_nxt == MHP_PAY && st_r != MHP_PAY)
        hv_r <= 1'b1;
      // policy bit per version enables acknowledgement
      ack_r <= auto_ack_receive_state
             & ack_version_policy[ver];     // see R05
    end
  end

  // outputs
  assign hdr_valid       = hv_r;
  assign frame_ctrl      = fc_r;
  assign seq_num         = seq_r;
  assign dst_mode        = dam;
  assign src_mode        = sam;
  assign frame_ver       = ver;
  assign dst_present     = dam[1];                      // see R02
  assign src_present     = sam[1];
  assign src_pan_present = sam[1] & ~(panc & dam[1]);   // see R10
  assign addr_mode_rsvd  = (dam == MHP_AM_RSVD) |
                           (sam == MHP_AM_RSVD);        // see R02
  assign ver_rsvd        = ver[1];                      // see R04
  assign sec_2006        = sec & (ver == 2'h1);         // see R14
  assign sec_2003        = sec & (ver == 2'h0);         // see R14
  assign filter_bits     = {fc_r[15:10], fc_r[6],
                            fc_r[3], fc_r[2:0]};        // see R13
  assign dst_off         = doff_r;
  assign src_off         = soff_r;
  assign aux_off         = aoff_r;
  assign pay_off         = poff_r;
  assign fcs_off         = foff_r;                      // see R12
  assign ack_allow       = ack_r & hv_r;
  assign ack_seq         = seq_r;                       // see R08

  // assertions
  sequence seq_octet_s;
    take && st_r == MHP_SEQ;
  endsequence

  sequence dst_end_s;
    take && st_r == MHP_DST && fld_end;
  endsequence

  // sequence octet and its copy into the acknowledgement
  seq_capture_a: assert property (                            // see R07
    @(posedge core_clk) disable iff (!rst_b)
    seq_octet_s |=> seq_r == $past(byt))
    else $error("sequence octet not captured");
  ack_seq_a: assert property (                                // see R08
    @(posedge core_clk) disable iff (!rst_b)
    seq_octet_s |=> ack_seq == $past(byt))
    else $error("ack sequence differs");
  // field order, destination before source
  dst_order_a: assert property (                              // see R09
    @(posedge core_clk) disable iff (!rst_b)
    (seq_octet_s and (dlen != 4'h0 && !f_data[8]))
      |=> st_r == MHP_DST)
    else $error("destination not first");
  src_order_a: assert property (                              // see R09
    @(posedge core_clk) disable iff (!rst_b)
    (dst_end_s and (slen != 4'h0 && !f_data[8]))
      |=> st_r == MHP_SRC)
    else $error("source not after destination");
  // field lengths from the addressing modes, security format and ack policy
  dst_len_a: assert property (                                // see R01
    @(posedge core_clk) disable iff (!rst_b)
    dam == MHP_AM_EXT |-> dlen == 4'hA)
    else $error("extended destination length wrong");
  dst_short_a: assert property (                              // see R03
    @(posedge core_clk) disable iff (!rst_b)
    dam == MHP_AM_SHORT |-> dlen == 4'h4)
    else $error("short destination length wrong");
  rsvd_mode_a: assert property (                              // see R02
    @(posedge core_clk) disable iff (!rst_b)
    dam == MHP_AM_RSVD |-> dlen == 4'h0 && addr_mode_rsvd)
    else $error("reserved mode not treated as absent");
  src_comp_a: assert property (                               // see R10
    @(posedge core_clk) disable iff (!rst_b)
    (panc && dam == MHP_AM_SHORT && sam == MHP_AM_SHORT)
      |-> slen == 4'h2)
    else $error("compressed source length wrong");
  aux_gate_a: assert property (                               // see R11
    @(posedge core_clk) disable iff (!rst_b)
    st_r == MHP_AUX |-> sec)
    else $error("aux header without security");
  sec_fmt_a: assert property (                                // see R14
    @(posedge core_clk) disable iff (!rst_b)
    sec |-> (sec_2006 ^ sec_2003 ^ ver_rsvd))
    else $error("secured format ambiguous");
  ack_pol_a: assert property (                                // see R05
    @(posedge core_clk) disable iff (!rst_b)
    ack_allow |-> $past(auto_ack_receive_state
                        && ack_version_policy[ver]))
    else $error("ack against version policy");
  // offsets, header valid and frame end
  off_chain_a: assert property (                              // see R19
    @(posedge core_clk) disable iff (!rst_b)
    seq_octet_s |=> pay_off == 8'(doff_r + dlen + slen + alen))
    else $error("payload offset wrong");
  pay_count_a: assert property (                              // see R19
    @(posedge core_clk) disable iff (!rst_b)
    st_r == MHP_PAY |-> left_r == 4'h0)
    else $error("payload entered inside a field");
  hdr_rise_a: assert property (                               // see R19
    @(posedge core_clk) disable iff (!rst_b)
    $rose(hv_r) |-> st_r == MHP_PAY)
    else $error("header valid outside payload");
  fcs_off_a: assert property (                                // see R12
    @(posedge core_clk) disable iff (!rst_b)
    seq_octet_s |=> fcs_off == 8'($past(frame_len) - 8'h02))
    else $error("checksum offset wrong");
  last_done_a: assert property (                              // see R12
    @(posedge core_clk) disable iff (!rst_b)
    (take && f_data[8]) |=> st_r == MHP_DONE)
    else $error("final octet did not end frame");
endmodule : mhp_parser

// ---- mhp_tx_model.sv ----
// file: behavioural remote transmitter feeding received octets
`timescale 1ns/10ps
module mhp_tx_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // octet stream towards the parser
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_last
);
  // idle levels at time zero
  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_last  = 1'b0;
  end

  // one frame, each octet held until taken; slow adds a gap per octet
  task automatic send(input logic [15:0] fc, input logic [7:0] seq,
                      input logic [7:0] flen, input logic slow);
    int i;
    for (i = 0; i < flen; i++)
    begin
      rx_valid <= 1'b1;
      rx_data  <= (i == 0) ? fc[7:0] : (i == 1) ? fc[15:8] :
                  (i == 2) ? seq : 8'($urandom);
      rx_last  <= (i == flen - 1);
      do @(posedge core_clk); while (rx_ready !== 1'b1);
      if (slow)
      begin
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data;  // released line shows no stale octet
        rx_last  <= 1'b0;
        @(posedge core_clk);
      end
    end
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
    rx_last  <= 1'b0;
  endtask : send
endmodule : mhp_tx_model

// ---- testbench.sv ----
// file: self-checking bench for the mac header field parser
`timescale 1ns/10ps
module testbench;
  import mhp_pkg::*;
  logic core_clk, rst_b, rx_valid, rx_ready, rx_last, auto_ack, hdr_valid;
  logic [7:0] rx_data, frame_len, seq_num, ack_seq, dst_off, src_off;
  logic [7:0] aux_off, pay_off, fcs_off;
  logic [3:0] pol;
  logic [15:0] frame_ctrl;
  logic [1:0] dst_mode, src_mode, frame_ver;
  logic dst_pr, src_pr, span_pr, am_rsvd, ver_rsvd, s06, s03, ack_allow;
  logic [10:0] filter_bits;
  int err_total, checks_done, cycles;

  // clock at 40 ns
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  mhp_tx_model tx (.core_clk(core_clk), .rst_b(rst_b), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last));
  mhp_parser dut (.core_clk(core_clk), .rst_b(rst_b), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last),
    .auto_ack_receive_state(auto_ack), .ack_version_policy(pol),
    .frame_len(frame_len), .hdr_valid(hdr_valid), .frame_ctrl(frame_ctrl),
    .seq_num(seq_num), .dst_mode(dst_mode), .src_mode(src_mode),
    .frame_ver(frame_ver), .dst_present(dst_pr), .src_present(src_pr),
    .src_pan_present(span_pr), .addr_mode_rsvd(am_rsvd),
    .ver_rsvd(ver_rsvd), .sec_2006(s06), .sec_2003(s03),
    .filter_bits(filter_bits), .dst_off(dst_off), .src_off(src_off),
    .aux_off(aux_off), .pay_off(pay_off), .fcs_off(fcs_off),
    .ack_allow(ack_allow), .ack_seq(ack_seq));

  // value comparison, counted
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // octets of an address field without its PAN id
  function automatic int alen(input logic [1:0] m);
    alen = (m == 2'h3) ? 8 : (m == 2'h2) ? 2 : 0;
  endfunction : alen

  // send one frame and compare every decoded field
  task automatic run_frame(input logic [15:0] fc, input logic slow);
    logic [7:0] sq, fl;
    logic spp;
    int dl, sl, ao, po, n;
    sq  = 8'($urandom);
    dl  = alen(fc[11:10]) + (fc[11] ? 2 : 0);
    spp = fc[15] & !(fc[11] & fc[6]);
    sl  = alen(fc[15:14]) + (spp ? 2 : 0);
    ao  = 3 + dl + sl;
    po  = ao + (fc[3] ? int'(MHP_LEN_AUX) : 0);
    fl  = 8'(po + 6 + $urandom_range(6));
    @(posedge core_clk);
    frame_len <= fl;
    pol       <= 4'($urandom);
    auto_ack  <= 1'($urandom);
    fork
      tx.send(fc, sq, fl, slow);
      begin
        n = 0;
        do begin @(negedge core_clk); n++; end
        while (hdr_valid !== 1'b1 && n < 200);
        chk(hdr_valid, 1'b1, "header valid");
        chk(rx_ready, 1'b1, "ready");
        chk(frame_ctrl, fc, "control");
        chk(seq_num, sq, "sequence");
        chk({dst_mode, src_mode, frame_ver}, {fc[11:10], fc[15:14],
            fc[13:12]}, "modes");
        chk({dst_pr, src_pr, span_pr, am_rsvd}, {fc[11], fc[15], spp,
            fc[11:10] == 2'h1 || fc[15:14] == 2'h1}, "present");
        chk({ver_rsvd, s06, s03}, {fc[13], fc[3] && fc[13:12] == 2'h1,
            fc[3] && fc[13:12] == 2'h0}, "version");
        chk(filter_bits, {fc[15:10], fc[6], fc[3], fc[2:0]}, "filter");
        chk({dst_off, src_off}, {8'h03, 8'(3 + dl)}, "addr off");
        chk({aux_off, pay_off}, {8'(ao), 8'(po)}, "aux off");
        chk(fcs_off, 16'(fl - 8'h02), "fcs off");
        @(negedge core_clk);
        @(negedge core_clk);
        chk(ack_allow, auto_ack & pol[fc[13:12]], "ack");
        chk(ack_seq, sq, "ack seq");
      end
    join
    repeat (3) @(negedge core_clk);
    chk(hdr_valid, 1'b0, "frame end");
  endtask : run_frame

  // report and stop
  task give_verdict;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  // hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      give_verdict;
    end
  end

  // main sequence: corner frames, then random ones
  initial
  begin
    logic [15:0] fc;
    logic [15:0] corner [6];
    corner = '{16'h0002, 16'hCC41, 16'h8849, 16'h5C01, 16'hA823, 16'hFC0B};
    void'($urandom(32'h12bddbe2));
    {rst_b, auto_ack, pol, frame_len} = '0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    chk({rx_ready, hdr_valid, ack_allow}, 3'h4, "reset state");
    foreach (corner[i])
      run_frame(corner[i], 1'(i));
    repeat (40)
    begin
      fc = 16'($urandom);
      if (fc[11:10] == 2'h0 && fc[15:14] == 2'h0)
        fc[2:0] = 3'h2;
      run_frame(fc, 1'($urandom));
    end
    give_verdict;
  end
endmodule : testbench
